// ==== rtl/alu_top.sv ====
// module: 16-bit signed arithmetic and logic unit of the sequence-program engine
`timescale 1ns/1ps
module alu_top (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic SCAN_I,
	input wire logic CMD_COND_I,
	input wire alu_pkg::alu_cmd_type CMD_I,
	input wire logic ERR_CLR_I,
	output logic RES_VALID_O,
	output logic RES_WIDE_O,
	output logic [15:0] RES_LO_O,
	output logic [15:0] RES_HI_O,
	output logic [15:0] RES_MASK_O,
	output logic OPERATION_ERROR_FLAG_O,
	output logic ERROR_LATCH_FLAG_O,
	output logic CARRY_O
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	alu_pkg::alu_state_type state_ff; // all registered state
	alu_pkg::alu_state_type nxt_state; // next state
	logic rise; // condition rose since previous scan
	logic exec; // instruction runs in this cycle
	logic [15:0] opa; // first operand after form select
	logic [15:0] opb; // second operand after form select
	logic [15:0] quot; // divide quotient
	logic [15:0] rem; // divide remainder
	logic [31:0] prod; // signed product
	logic [15:0] word_res; // single-word result
	logic [15:0] dmask; // digit mask for a bit group
	logic wide_op; // multiply or divide
	logic bad_dst; // forbidden destination
	logic div_zero; // zero divisor
	logic err_now; // operation abandoned

	// ------------------------------------------------------------------
	// sub-blocks
	// ------------------------------------------------------------------
	// edge qualifier for pulse forms
	alu_rise_det u_rise (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.scan_i(SCAN_I),
		.cond_i(CMD_COND_I),
		.rise_o(rise)
	);

	// divider works on the selected operands
	alu_sdiv u_div (
		.dividend_i(opa),
		.divisor_i(opb),
		.quot_o(quot),
		.rem_o(rem)
	);

	// ------------------------------------------------------------------
	// operand selection and datapath
	// ------------------------------------------------------------------
	// pulse form waits for a rising condition, level form runs each scan its condition is high
	assign exec = SCAN_I & (CMD_I.pulse ? rise : CMD_COND_I);

	// two-operand forms take the destination as first operand
	always_comb begin
		opa = CMD_I.form3 ? CMD_I.src1 : CMD_I.dst_val;
		opb = CMD_I.form3 ? CMD_I.src2 : CMD_I.src1;
		// product sign lands in bit 31 by signed extension
		prod = 32'($signed(opa) * $signed(opb));
		// one digit is four bits, four digits the full word
		dmask = 16'(17'h0FFFF >> (alu_pkg::WORD_W - alu_pkg::DIGIT_BITS * (32'(CMD_I.digits) + 1)));
		wide_op = (CMD_I.op == alu_pkg::ALU_MUL) || (CMD_I.op == alu_pkg::ALU_DIV);
		bad_dst = wide_op && ((CMD_I.dst_kind == alu_pkg::DST_UPPER_ACCUMULATOR) ||
			(CMD_I.dst_kind == alu_pkg::DST_INDEX));
		div_zero = (CMD_I.op == alu_pkg::ALU_DIV) && (opb == alu_pkg::WORD_RST);
		err_now = bad_dst | div_zero;
		word_res = alu_pkg::WORD_RST;
		unique case (CMD_I.op)
			// sums and differences wrap in 16 bits, no carry kept
			alu_pkg::ALU_ADD: begin
				word_res = 16'(opa + opb);
			end
			alu_pkg::ALU_SUB: begin
				word_res = 16'(opa - opb);
			end
			alu_pkg::ALU_MUL: begin
				word_res = prod[15:0];
			end
			alu_pkg::ALU_DIV: begin
				word_res = quot;
			end
			alu_pkg::ALU_WORD_TRANSFER: begin
				word_res = CMD_I.src1;
			end
			// logic ops act bit by bit on opa and opb
			alu_pkg::ALU_BITWISE_AND: begin
				word_res = opa & opb;
			end
			alu_pkg::ALU_BITWISE_OR: begin
				word_res = opa | opb;
			end
			alu_pkg::ALU_BITWISE_XOR: begin
				word_res = opa ^ opb;
			end
			alu_pkg::ALU_BITWISE_XNOR: begin
				word_res = ~(opa ^ opb);
			end
			alu_pkg::ALU_TWOS_COMPLEMENT: begin
				word_res = 16'(~CMD_I.dst_val + 16'h0001);
			end
			default: begin
				word_res = alu_pkg::WORD_RST;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	// results are held between writes; strobes last one cycle
	always_comb begin
		nxt_state = state_ff;
		nxt_state.res_valid = 1'b0;
		nxt_state.op_err = 1'b0;
		nxt_state.carry = 1'b0;
		if (SCAN_I) begin
			nxt_state.last_cond = CMD_COND_I;
		end
		// software clear loses to a fresh error in the same cycle
		if (ERR_CLR_I) begin
			nxt_state.err_latch = 1'b0;
		end
		if (exec && err_now) begin
			// abandoned: no write, destination keeps its value
			nxt_state.op_err = 1'b1;
			nxt_state.err_latch = 1'b1;
		end else if (exec) begin
			nxt_state.res_valid = 1'b1;
			nxt_state.res_wide = 1'b0;
			if (CMD_I.dst_kind == alu_pkg::DST_BIT_GROUP) begin
				// only the digit bits are driven, higher bits read zero
				nxt_state.res_mask = dmask;
				nxt_state.res_lo = word_res & dmask;
			end else begin
				nxt_state.res_mask = alu_pkg::MASK_FULL;
				nxt_state.res_lo = word_res;
				if (CMD_I.op == alu_pkg::ALU_MUL) begin
					nxt_state.res_wide = 1'b1;
					nxt_state.res_hi = prod[31:16];
				end else if (CMD_I.op == alu_pkg::ALU_DIV) begin
					nxt_state.res_wide = 1'b1;
					nxt_state.res_hi = rem;
				end
			end
		end
	end

	// state register
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ------------------------------------------------------------------
	// outputs, all straight from the state register
	// ------------------------------------------------------------------
	assign RES_VALID_O = state_ff.res_valid;
	assign RES_WIDE_O = state_ff.res_wide;
	assign RES_LO_O = state_ff.res_lo;
	assign RES_HI_O = state_ff.res_hi;
	assign RES_MASK_O = state_ff.res_mask;
	assign OPERATION_ERROR_FLAG_O = state_ff.op_err;
	assign ERROR_LATCH_FLAG_O = state_ff.err_latch;
	assign CARRY_O = state_ff.carry;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);

	// word-destination instruction of a given kind, zero divisor not excluded
	sequence s_word(alu_pkg::alu_op_type o);
		exec && CMD_I.op == o && CMD_I.dst_kind == alu_pkg::DST_WORD;
	endsequence

	// error strobe with sticky flag set and no write strobe, all in one cycle
	sequence s_err_seen;
		OPERATION_ERROR_FLAG_O && !RES_VALID_O && ERROR_LATCH_FLAG_O;
	endsequence

	a_sub_two_op: assert property (s_word(alu_pkg::ALU_SUB) ##0 !CMD_I.form3 |=>
		RES_VALID_O && RES_LO_O == 16'($past(CMD_I.dst_val) - $past(CMD_I.src1)))
		else $error("two-operand subtract wrong");

	a_sub_three_op: assert property (s_word(alu_pkg::ALU_SUB) ##0 CMD_I.form3 |=>
		RES_VALID_O && RES_LO_O == 16'($past(CMD_I.src1) - $past(CMD_I.src2)))
		else $error("three-operand subtract wrong");

	a_add_three_op: assert property (s_word(alu_pkg::ALU_ADD) ##0 CMD_I.form3 |=>
		RES_LO_O == 16'($past(CMD_I.src1) + $past(CMD_I.src2)))
		else $error("three-operand add wrong");

	a_sign_wrap: assert property (s_word(alu_pkg::ALU_ADD) ##0 CMD_I.form3 &&
		CMD_I.src1 == 16'h7FFF && CMD_I.src2 == 16'h0001 |=> RES_LO_O[alu_pkg::SIGN_BIT])
		else $error("add overflow did not wrap negative");

	a_no_carry: assert property (##1 !CARRY_O)
		else $error("carry flag raised");

	a_mul_product: assert property (s_word(alu_pkg::ALU_MUL) |=> RES_WIDE_O &&
		{RES_HI_O, RES_LO_O} == 32'($signed($past(opa)) * $signed($past(opb))))
		else $error("product wrong");

	a_digit_mask: assert property (exec && !err_now &&
		CMD_I.dst_kind == alu_pkg::DST_BIT_GROUP |=> !RES_WIDE_O &&
		RES_MASK_O == 16'(17'h0FFFF >> (12 - 4 * 32'($past(CMD_I.digits)))) &&
		(RES_LO_O & ~RES_MASK_O) == 16'h0000)
		else $error("bit group mask wrong");

	a_div_split: assert property (s_word(alu_pkg::ALU_DIV) ##0 opb != 16'h0000 &&
		!(opa == alu_pkg::MIN_NEG && opb == alu_pkg::MINUS_ONE) |=> RES_WIDE_O &&
		32'($signed(RES_LO_O) * $signed($past(opb))) + 32'($signed(RES_HI_O)) ==
		32'($signed($past(opa))))
		else $error("quotient and remainder do not rebuild dividend");

	a_rem_sign: assert property (s_word(alu_pkg::ALU_DIV) ##0 opb != 16'h0000 |=>
		RES_HI_O == 16'h0000 || RES_HI_O[alu_pkg::SIGN_BIT] == $past(opa[15]))
		else $error("remainder sign wrong");

	a_div_zero: assert property (exec && div_zero |=> s_err_seen)
		else $error("zero divisor not reported");

	a_bad_dest: assert property (exec && bad_dst && !ERR_CLR_I ##1 !ERR_CLR_I |->
		s_err_seen ##1 ERROR_LATCH_FLAG_O)
		else $error("forbidden destination not reported");

	a_err_wins: assert property (exec && err_now && ERR_CLR_I |=> ERROR_LATCH_FLAG_O)
		else $error("error lost against a clear");

	a_err_clear: assert property (ERR_CLR_I && !(exec && err_now) |=> !ERROR_LATCH_FLAG_O)
		else $error("error latch not cleared");

	a_transfer_copy: assert property (s_word(alu_pkg::ALU_WORD_TRANSFER) |=>
		RES_LO_O == $past(CMD_I.src1) && RES_MASK_O == 16'hFFFF)
		else $error("transfer altered data");

	a_hold_value: assert property (!exec |=> $stable(RES_LO_O) && $stable(RES_HI_O))
		else $error("result changed without a write");

	a_and_bits: assert property (s_word(alu_pkg::ALU_BITWISE_AND) |=>
		RES_LO_O == ($past(opa) & $past(opb)))
		else $error("and wrong");

	a_or_bits: assert property (s_word(alu_pkg::ALU_BITWISE_OR) |=>
		~RES_LO_O == (~$past(opa) & ~$past(opb)))
		else $error("or wrong");

	a_xor_bits: assert property (s_word(alu_pkg::ALU_BITWISE_XOR) |=>
		(RES_LO_O ^ $past(opa)) == $past(opb))
		else $error("xor wrong");

	a_xnor_bits: assert property (s_word(alu_pkg::ALU_BITWISE_XNOR) |=>
		(~RES_LO_O ^ $past(opa)) == $past(opb))
		else $error("xnor wrong");

	a_neg_value: assert property (s_word(alu_pkg::ALU_TWOS_COMPLEMENT) |=>
		16'(RES_LO_O + $past(CMD_I.dst_val)) == 16'h0000)
		else $error("sign reversal wrong");

	a_pulse_once: assert property (SCAN_I && CMD_I.pulse && CMD_COND_I &&
		state_ff.last_cond |=> !RES_VALID_O && !OPERATION_ERROR_FLAG_O)
		else $error("pulse form ran without a rising condition");

	a_level_scan: assert property (SCAN_I && !CMD_I.pulse && CMD_COND_I |=>
		RES_VALID_O != OPERATION_ERROR_FLAG_O)
		else $error("level form skipped a scan");

endmodule

// ==== rtl/alu_pkg.sv ====
// package: constants, commands and carriers for the 16-bit arithmetic and logic unit
package alu_pkg;

	// ------------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------------
	localparam int WORD_W = 16; // one data word
	localparam int DIGIT_BITS = 4; // bits selected by one digit of a bit group
	localparam logic [15:0] WORD_RST = 16'h0000; // result words after reset
	localparam logic [15:0] MASK_FULL = 16'hFFFF; // word destination writes all bits
	localparam logic [15:0] MIN_NEG = 16'h8000; // most negative word
	localparam logic [15:0] MINUS_ONE = 16'hFFFF; // word value -1
	localparam int SIGN_BIT = 15; // sign of a word
	localparam int PROD_SIGN_BIT = 31; // sign of a product

	// ------------------------------------------------------------------
	// operations; each one runs in level or pulse form
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ALU_ADD,
		ALU_SUB,
		ALU_MUL,
		ALU_DIV,
		ALU_WORD_TRANSFER,
		ALU_BITWISE_AND,
		ALU_BITWISE_OR,
		ALU_BITWISE_XOR,
		ALU_BITWISE_XNOR,
		ALU_TWOS_COMPLEMENT
	} alu_op_type;

	// destination classes
	typedef enum logic [1:0] {
		DST_WORD,
		DST_BIT_GROUP,
		DST_UPPER_ACCUMULATOR,
		DST_INDEX
	} alu_dst_type;

	// one instruction as offered by the program engine
	typedef struct packed {
		alu_op_type op; // operation
		logic pulse; // 1: pulse form, 0: level form
		logic form3; // 1: dst = src1 op src2, 0: dst = dst op src1
		alu_dst_type dst_kind; // destination class
		logic [1:0] digits; // digit count minus one, 0..3
		logic [15:0] dst_val; // present destination content
		logic [15:0] src1; // first source
		logic [15:0] src2; // second source
	} alu_cmd_type;

	// registered state of the top module
	typedef struct packed {
		logic res_valid; // one-cycle write strobe
		logic res_wide; // both words are written
		logic [15:0] res_lo; // low word
		logic [15:0] res_hi; // high word
		logic [15:0] res_mask; // bits of low word written
		logic op_err; // one-cycle operation error
		logic err_latch; // sticky error
		logic carry; // stays low
		logic last_cond; // condition at last scan, for checks
	} alu_state_type;

	// state of the rising-edge qualifier
	typedef struct packed {
		logic prev; // condition seen at the previous scan
	} alu_rise_state_type;

endpackage

// ==== rtl/alu_rise_det.sv ====
// module: rising-edge qualifier of a command condition, sampled once per scan
`timescale 1ns/1ps
module alu_rise_det (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic scan_i, // a scan takes place in this cycle
	input wire logic cond_i, // command condition
	output logic rise_o // condition rose since the previous scan
);

	alu_pkg::alu_rise_state_type state_ff; // registered state
	alu_pkg::alu_rise_state_type nxt_state; // next state

	// rise is judged between scans, not between clocks, so an idle gap keeps the edge
	assign rise_o = scan_i & cond_i & ~state_ff.prev;

	// capture the condition on each scan only
	always_comb begin
		nxt_state = state_ff;
		if (scan_i) begin
			nxt_state.prev = cond_i;
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

endmodule

// ==== rtl/alu_sdiv.sv ====
// module: signed 16-bit divide with truncated quotient and signed remainder
`timescale 1ns/1ps
module alu_sdiv (
	input wire logic [15:0] dividend_i,
	input wire logic [15:0] divisor_i, // caller flags zero, divider then outputs 0
	output logic [15:0] quot_o,
	output logic [15:0] rem_o
);

	logic signed [16:0] num; // widened so -32768 / -1 wraps instead of trapping
	logic signed [16:0] den; // widened divisor
	logic signed [16:0] q17; // wide quotient
	logic signed [16:0] r17; // wide remainder

	// sign extension to 17 bits; remainder takes the sign of the dividend
	always_comb begin
		num = $signed({dividend_i[alu_pkg::SIGN_BIT], dividend_i});
		den = $signed({divisor_i[alu_pkg::SIGN_BIT], divisor_i});
		q17 = 17'sh00000;
		r17 = 17'sh00000;
		if (divisor_i != alu_pkg::WORD_RST) begin
			q17 = num / den;
			r17 = num % den;
		end
		quot_o = q17[15:0];
		rem_o = r17[15:0];
	end

endmodule

// ==== testbench/alu_eng_model.sv ====
// file: program-engine model that presents one instruction per requested scan
`timescale 1ns/1ps
module alu_eng_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic req_i, // bench asks for one scan
	input wire logic cond_i, // condition for that scan
	input wire alu_pkg::alu_cmd_type cmd_i, // instruction for that scan
	output logic scan_o, // scan strobe to the unit
	output logic cond_o, // condition to the unit
	output alu_pkg::alu_cmd_type cmd_o // operands to the unit
);
	// ------------------------------------------------------------------
	// scan issue
	// ------------------------------------------------------------------
	// outside a scan the operands flip every cycle, so a unit that
	// samples them at the wrong time shows it instead of reading stale data
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scan_o <= 1'b0;
			cond_o <= 1'b0;
			cmd_o <= '0;
		end else if (req_i) begin
			scan_o <= 1'b1;
			cond_o <= cond_i;
			cmd_o <= cmd_i;
		end else begin
			scan_o <= 1'b0;
			cond_o <= ~cond_o;
			cmd_o <= alu_pkg::alu_cmd_type'(~cmd_o);
		end
	end
endmodule

// ==== testbench/tb.sv ====
// file: self-checking testbench of the arithmetic and logic unit
`timescale 1ns/1ps
module tb;
	localparam alu_pkg::alu_dst_type DW = alu_pkg::DST_WORD; // word destination
	localparam alu_pkg::alu_dst_type DB = alu_pkg::DST_BIT_GROUP; // bit group
	logic clk; // 250 MHz
	logic rst_b; // async reset, active low
	logic req; // scan request to the model
	logic cond; // condition to the model
	alu_pkg::alu_cmd_type cmd; // instruction to the model
	logic err_clr; // error latch clear
	logic scan, cond_m; // model to unit
	alu_pkg::alu_cmd_type cmd_m;
	logic res_valid, res_wide, op_err, err_latch, carry;
	logic [15:0] res_lo, res_hi, res_mask;
	logic [63:0] obs; // all outputs in one word
	int n_errors;
	int comparisons;
	logic [15:0] k_lo, k_hi, k_mask; // expected held outputs
	logic k_wide, k_latch;

	assign obs = {11'h000, res_valid, op_err, err_latch, carry, res_wide, res_mask, res_hi, res_lo};

	// ------------------------------------------------------------------
	// clock, model and unit
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	alu_eng_model eng_u (.clk_i(clk), .rst_b_i(rst_b), .req_i(req), .cond_i(cond),
		.cmd_i(cmd), .scan_o(scan), .cond_o(cond_m), .cmd_o(cmd_m));

	alu_top dut_u (.CLK_I(clk), .RST_B_I(rst_b), .SCAN_I(scan), .CMD_COND_I(cond_m),
		.CMD_I(cmd_m), .ERR_CLR_I(err_clr), .RES_VALID_O(res_valid), .RES_WIDE_O(res_wide),
		.RES_LO_O(res_lo), .RES_HI_O(res_hi), .RES_MASK_O(res_mask),
		.OPERATION_ERROR_FLAG_O(op_err), .ERROR_LATCH_FLAG_O(err_latch), .CARRY_O(carry));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] expd);
		comparisons++;
		if (seen !== expd) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask

	// expected word after a write; carry always low
	function automatic logic [63:0] ew(input logic [15:0] lo, hi, mask, input logic wide);
		k_lo = lo;
		k_hi = hi;
		k_mask = mask;
		k_wide = wide;
		return {11'h000, 1'b1, 1'b0, k_latch, 1'b0, wide, mask, hi, lo};
	endfunction

	// expected word when nothing is written; e marks an error pulse
	function automatic logic [63:0] en(input logic e);
		if (e) begin
			k_latch = 1'b1;
		end
		return {11'h000, 1'b0, e, k_latch, 1'b0, k_wide, k_mask, k_hi, k_lo};
	endfunction

	function automatic alu_pkg::alu_cmd_type mk(input alu_pkg::alu_op_type op,
		input logic pulse, form3, input alu_pkg::alu_dst_type dk, input logic [1:0] dig,
		input logic [15:0] dv, s1, s2);
		return '{op, pulse, form3, dk, dig, dv, s1, s2};
	endfunction

	// one scan; returns once the answer cycle has settled
	task automatic go(input logic c, input alu_pkg::alu_cmd_type x);
		@(posedge clk);
		req <= 1'b1;
		cond <= c;
		cmd <= x;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic clear_err();
		@(posedge clk);
		err_clr <= 1'b1;
		@(posedge clk);
		err_clr <= 1'b0;
		#1;
		k_latch = 1'b0;
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_arith();
		logic [15:0] m;
		go(1'b1, mk(alu_pkg::ALU_SUB, 1'b0, 1'b0, DW, 2'h0, 16'h0005, 16'h0008, 16'h0000));
		check(obs, ew(16'hFFFD, k_hi, 16'hFFFF, 1'b0));
		go(1'b1, mk(alu_pkg::ALU_SUB, 1'b0, 1'b1, DW, 2'h0, 16'h1234, 16'h8000, 16'h0001));
		check(obs, ew(16'h7FFF, k_hi, 16'hFFFF, 1'b0));
		go(1'b1, mk(alu_pkg::ALU_ADD, 1'b0, 1'b1, DW, 2'h0, 16'h0000, 16'h7FFF, 16'h0001));
		check(obs, ew(16'h8000, k_hi, 16'hFFFF, 1'b0));
		for (int d = 0; d < 4; d++) begin
			m = 16'((32'h1 << (alu_pkg::DIGIT_BITS * (d + 1))) - 1);
			go(1'b1, mk(alu_pkg::ALU_SUB, 1'b0, 1'b1, DB, 2'(d), 16'h0000, 16'h0003, 16'h0010));
			check(obs, ew(16'hFFF3 & m, k_hi, m, 1'b0));
		end
		$display("arith test done");
	endtask

	task automatic t_muldiv();
		logic [15:0] a [4];
		logic [15:0] b [4];
		int p, q, r;
		a = '{16'hFFFB, 16'h0005, 16'hFFFB, 16'h8000};
		b = '{16'h0003, 16'hFFFD, 16'hFFFD, 16'hFFFF};
		for (int i = 0; i < 4; i++) begin
			p = int'($signed(a[i])) * int'($signed(b[i]));
			q = int'($signed(a[i])) / int'($signed(b[i]));
			r = int'($signed(a[i])) % int'($signed(b[i]));
			go(1'b1, mk(alu_pkg::ALU_MUL, 1'b0, 1'b1, DW, 2'h0, 16'h0000, a[i], b[i]));
			check(obs, ew(p[15:0], p[31:16], 16'hFFFF, 1'b1));
			go(1'b1, mk(alu_pkg::ALU_DIV, 1'b0, 1'b1, DW, 2'h0, 16'h0000, a[i], b[i]));
			check(obs, ew(q[15:0], r[15:0], 16'hFFFF, 1'b1));
		end
		p = 32'h5678 * 32'h1234;
		go(1'b1, mk(alu_pkg::ALU_MUL, 1'b0, 1'b1, DB, 2'h0, 16'h0000, 16'h5678, 16'h1234));
		check(obs, ew(p[15:0] & 16'h000F, k_hi, 16'h000F, 1'b0));
		go(1'b1, mk(alu_pkg::ALU_DIV, 1'b0, 1'b1, DB, 2'h3, 16'h0000, 16'hFFFB, 16'h0003));
		check(obs, ew(16'hFFFF, k_hi, 16'hFFFF, 1'b0));
		$display("multiply and divide test done");
	endtask

	task automatic t_err();
		go(1'b1, mk(alu_pkg::ALU_DIV, 1'b0, 1'b1, DW, 2'h0, 16'h0000, 16'h0007, 16'h0000));
		check(obs, en(1'b1));
		@(posedge clk);
		#1;
		check(obs, en(1'b0));
		clear_err();
		check(obs, en(1'b0));
		for (int i = 0; i < 4; i++) begin
			go(1'b1, mk(i[0] ? alu_pkg::ALU_DIV : alu_pkg::ALU_MUL, 1'b0, 1'b1,
				i[1] ? alu_pkg::DST_INDEX : alu_pkg::DST_UPPER_ACCUMULATOR, 2'h0, 16'h0000,
				16'h0009, 16'h0002));
			check(obs, en(1'b1));
			clear_err();
		end
		// clear and a fresh error on one edge: the error must win
		@(posedge clk);
		req <= 1'b1;
		cond <= 1'b1;
		cmd <= mk(alu_pkg::ALU_DIV, 1'b0, 1'b1, DW, 2'h0, 16'h0000, 16'h0007, 16'h0000);
		@(posedge clk);
		req <= 1'b0;
		err_clr <= 1'b1;
		@(posedge clk);
		err_clr <= 1'b0;
		#1;
		check(obs, en(1'b1));
		clear_err();
		check(obs, en(1'b0));
		$display("error test done");
	endtask

	task automatic t_logic();
		localparam logic [15:0] A = 16'h3333;
		localparam logic [15:0] B = 16'h5555;
		alu_pkg::alu_op_type ops [4];
		logic [15:0] r [4];
		logic [15:0] dv;
		ops = '{alu_pkg::ALU_BITWISE_AND, alu_pkg::ALU_BITWISE_OR, alu_pkg::ALU_BITWISE_XOR,
			alu_pkg::ALU_BITWISE_XNOR};
		r = '{A & B, A | B, A ^ B, ~(A ^ B)};
		for (int i = 0; i < 5; i++) begin
			for (int pf = 0; pf < 2; pf++) begin
				dv = pf[0] ? 16'h8000 : 16'h0001;
				go(1'b0, mk(alu_pkg::ALU_ADD, 1'b0, 1'b1, DW, 2'h0, 16'h0000, A, B));
				check(obs, en(1'b0));
				if (i < 4) begin
					go(1'b1, mk(ops[i], pf[0], 1'b1, DW, 2'h0, 16'h0000, A, B));
					check(obs, ew(r[i], k_hi, 16'hFFFF, 1'b0));
				end else begin
					go(1'b1, mk(alu_pkg::ALU_TWOS_COMPLEMENT, pf[0], 1'b0, DW, 2'h0, dv, A, B));
					check(obs, ew(16'h0000 - dv, k_hi, 16'hFFFF, 1'b0));
				end
			end
		end
		go(1'b1, mk(alu_pkg::ALU_WORD_TRANSFER, 1'b0, 1'b0, DW, 2'h0, 16'h0000, 16'h9667, A));
		check(obs, ew(16'h9667, k_hi, 16'hFFFF, 1'b0));
		go(1'b0, mk(alu_pkg::ALU_WORD_TRANSFER, 1'b0, 1'b0, DW, 2'h0, 16'h0000, 16'h1111, A));
		check(obs, en(1'b0));
		$display("logic test done");
	endtask

	task automatic t_pulse();
		alu_pkg::alu_cmd_type x;
		x = mk(alu_pkg::ALU_SUB, 1'b1, 1'b1, DW, 2'h0, 16'h0000, 16'h0009, 16'h0002);
		go(1'b1, x);
		check(obs, ew(16'h0007, k_hi, 16'hFFFF, 1'b0));
		go(1'b1, x);
		check(obs, en(1'b0));
		x.pulse = 1'b0;
		go(1'b1, x);
		check(obs, ew(16'h0007, k_hi, 16'hFFFF, 1'b0));
		x.src1 = 16'h0004;
		go(1'b1, x);
		check(obs, ew(16'h0002, k_hi, 16'hFFFF, 1'b0));
		$display("pulse test done");
	endtask

	// ------------------------------------------------------------------
	// run control
	// ------------------------------------------------------------------
	task automatic close_out();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// about 50 scans of 3 cycles each; twenty times that is ample
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		close_out();
	end

	initial begin
		rst_b = 1'b0;
		req = 1'b0;
		cond = 1'b0;
		cmd = '0;
		err_clr = 1'b0;
		n_errors = 0;
		comparisons = 0;
		{k_lo, k_hi, k_mask, k_wide, k_latch} = '0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		check(obs, 64'h0);
		t_pulse();
		t_arith();
		t_muldiv();
		t_err();
		t_logic();
		close_out();
	end
endmodule
